// [cig_pkg.sv]
// package: register map, field layout and types of the custom and pin interrupt block
package cig_pkg;
	localparam int          ADDR_W            = 16;
	localparam int          DATA_W            = 32;
	localparam logic [15:0] OFS_EXT_CFG_0     = 16'h0a20;
	localparam logic [15:0] OFS_EXT_CFG_1     = 16'h0a24;
	localparam logic [15:0] OFS_EXT_CFG_2     = 16'h0a28;
	localparam logic [15:0] OFS_EXT_CLEAR     = 16'h0a30;
	localparam logic [15:0] OFS_CUSTOM_GEN    = 16'h209c;
	localparam logic [15:0] RST_EXT_CFG       = 16'h0000;
	localparam logic [15:0] RST_EXT_CLEAR     = 16'hc000;
	localparam logic [31:0] RST_CUSTOM_GEN    = 32'h00000010;
	localparam logic [27:0] CUSTOM_RSVD_VALUE = 28'h0000001;
	localparam int          POS_PIN0_MODE     = 0;
	localparam int          POS_PIN0_EN       = 3;
	localparam int          POS_PIN1_MODE     = 4;
	localparam int          POS_PIN1_EN       = 7;
	localparam int          NUM_CUSTOM        = 4;

	typedef enum logic [2:0]
	{
		CIG_RISE     = 3'b000,
		CIG_FALL     = 3'b001,
		CIG_BOTH     = 3'b010,
		CIG_HIGH     = 3'b011,
		CIG_LOW      = 3'b100,
		CIG_FALL_ALT = 3'b101,
		CIG_BOTH_ALT = 3'b110,
		CIG_HIGH_ALT = 3'b111
	} cig_mode_e;

	// one register access, as issued by either the host port or the sequencer
	typedef struct packed
	{
		logic              wr;
		logic              rd;
		logic [15:0]       addr;
		logic [31:0]       wdata;
	} cig_req_s;
endpackage

// [cig_int_config.sv]
// custom interrupt generation register and wake pin interrupt configuration and detection
`timescale 1ns/100ps
// Summary of operation
// - custom interrupt register writes accepted only from sequencer; host writes ignored.
// - host reads of custom interrupt register return meaningless data; not relied upon.
// - sequencer writing one to a custom flag raises that custom interrupt.
// - four custom flags at bits 3..0, reset zero, read and write-one-to-clear.
// - custom register resets to 0x00000010; bits 31..4 reserved read-only.
// - pin 1 enable bit 7 allows pin 1 events to wake from hibernate.
// - enable bit clear disables the pin interrupt, set enables it.
// - mode 000 rise, 001 fall, 010 either edge, 011 high, 100 low.
// - modes 101, 110, 111 alias 001, 010, 011.
// - pin 0 mode at bits 2..0, pin 1 mode at bits 6..4.
// - three configuration registers reset to zero: disabled, rising edge.
// - clear register is read/write with reset value 0xC000.
module cig_int_config
	import cig_pkg::*;
(
	input  wire logic              REF_CLK_IN,
	input  wire logic              RESET_N_IN,
	input  wire cig_req_s          HOST_REQ_IN,
	output logic [DATA_W-1:0]      HOST_RDATA_OUT,
	input  wire cig_req_s          SEQ_REQ_IN,
	output logic [DATA_W-1:0]      SEQ_RDATA_OUT,
	input  wire logic              WAKE_PIN_0_IN,
	input  wire logic              WAKE_PIN_1_IN,
	output logic [NUM_CUSTOM-1:0]  CUSTOM_IRQ_OUT,
	output logic [1:0]             PIN_IRQ_OUT,
	output logic                   WAKE_REQ_OUT
);

	logic [15:0]           ext_cfg_0;
	logic [15:0]           ext_cfg_1;
	logic [15:0]           ext_cfg_2;
	logic [15:0]           ext_clear;
	logic [NUM_CUSTOM-1:0] custom_flag;
	logic [1:0]            pin_meta;
	logic [1:0]            pin_sync;
	logic [1:0]            pin_prev;
	logic [1:0]            pin_event;

	// the sequencer wins when both ports write a shared register in one cycle
	function automatic logic [15:0] cfg_next(input logic [15:0] cur, input logic [15:0] ofs,
		input cig_req_s h, input cig_req_s s);
		logic [15:0] v;
		v = cur;
		if (h.wr && h.addr == ofs)
			v = h.wdata[15:0];
		if (s.wr && s.addr == ofs)
			v = s.wdata[15:0];
		return v;
	endfunction

	function automatic logic detect(input logic [2:0] mode, input logic now, input logic prev);
		logic d;
		d = 1'b0;
		unique case (cig_mode_e'(mode))
			CIG_RISE:                  d = now & ~prev;
			CIG_FALL, CIG_FALL_ALT:    d = ~now & prev;
			CIG_BOTH, CIG_BOTH_ALT:    d = now ^ prev;
			CIG_HIGH, CIG_HIGH_ALT:    d = now;
			CIG_LOW:                   d = ~now;
		endcase
		return d;
	endfunction

	function automatic logic [31:0] read_mux(input logic [15:0] a, input logic [31:0] custom_view,
		input logic [15:0] c0, input logic [15:0] c1, input logic [15:0] c2, input logic [15:0] cl);
		logic [31:0] r;
		r = 32'h00000000;
		if (a == OFS_EXT_CFG_0)
			r = {16'h0000, c0};
		else if (a == OFS_EXT_CFG_1)
			r = {16'h0000, c1};
		else if (a == OFS_EXT_CFG_2)
			r = {16'h0000, c2};
		else if (a == OFS_EXT_CLEAR)
			r = {16'h0000, cl};
		else if (a == OFS_CUSTOM_GEN)
			r = custom_view;
		return r;
	endfunction

	wire logic [15:0] next_ext_cfg_0 = cfg_next(ext_cfg_0, OFS_EXT_CFG_0, HOST_REQ_IN, SEQ_REQ_IN);
	wire logic [15:0] next_ext_cfg_1 = cfg_next(ext_cfg_1, OFS_EXT_CFG_1, HOST_REQ_IN, SEQ_REQ_IN);
	wire logic [15:0] next_ext_cfg_2 = cfg_next(ext_cfg_2, OFS_EXT_CFG_2, HOST_REQ_IN, SEQ_REQ_IN);
	wire logic [15:0] next_ext_clear = cfg_next(ext_clear, OFS_EXT_CLEAR, HOST_REQ_IN, SEQ_REQ_IN);

	// only the sequencer port is decoded for this register, so host writes vanish
	wire logic seq_custom_wr = SEQ_REQ_IN.wr && SEQ_REQ_IN.addr == OFS_CUSTOM_GEN;
	wire logic [NUM_CUSTOM-1:0] custom_ones = SEQ_REQ_IN.wdata[NUM_CUSTOM-1:0];
	// a written one sets a clear flag and clears a set one: set-then-acknowledge in one bit
	wire logic [NUM_CUSTOM-1:0] next_custom_flag =
		seq_custom_wr ? (custom_flag ^ custom_ones) : custom_flag;
	wire logic [31:0] custom_view = {CUSTOM_RSVD_VALUE, custom_flag};

	wire logic [2:0] pin0_detect_mode = ext_cfg_0[POS_PIN0_MODE +: 3];
	wire logic [2:0] pin1_detect_mode = ext_cfg_0[POS_PIN1_MODE +: 3];
	wire logic       pin0_wake_enable = ext_cfg_0[POS_PIN0_EN];
	wire logic       pin1_wake_enable = ext_cfg_0[POS_PIN1_EN];
	wire logic [1:0] next_pin_event;
	assign next_pin_event[0] = pin0_wake_enable & detect(pin0_detect_mode, pin_sync[0], pin_prev[0]);
	assign next_pin_event[1] = pin1_wake_enable & detect(pin1_detect_mode, pin_sync[1], pin_prev[1]);

	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			ext_cfg_0   <= RST_EXT_CFG;
			ext_cfg_1   <= RST_EXT_CFG;
			ext_cfg_2   <= RST_EXT_CFG;
			ext_clear   <= RST_EXT_CLEAR;
			custom_flag <= RST_CUSTOM_GEN[NUM_CUSTOM-1:0];
		end
		else
		begin
			ext_cfg_0   <= next_ext_cfg_0;
			ext_cfg_1   <= next_ext_cfg_1;
			ext_cfg_2   <= next_ext_cfg_2;
			ext_clear   <= next_ext_clear;
			custom_flag <= next_custom_flag;
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			pin_meta  <= 2'h0;
			pin_sync  <= 2'h0;
			pin_prev  <= 2'h0;
			pin_event <= 2'h0;
		end
		else
		begin
			pin_meta  <= {WAKE_PIN_1_IN, WAKE_PIN_0_IN};
			pin_sync  <= pin_meta;
			pin_prev  <= pin_sync;
			pin_event <= next_pin_event;
		end
	end

	// the host view of the custom register is not meaningful; zero is returned
	wire logic [31:0] host_rdata = (HOST_REQ_IN.addr == OFS_CUSTOM_GEN) ? 32'h00000000 :
		read_mux(HOST_REQ_IN.addr, custom_view, ext_cfg_0, ext_cfg_1, ext_cfg_2, ext_clear);
	wire logic [31:0] seq_rdata =
		read_mux(SEQ_REQ_IN.addr, custom_view, ext_cfg_0, ext_cfg_1, ext_cfg_2, ext_clear);

	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			HOST_RDATA_OUT <= 32'h00000000;
			SEQ_RDATA_OUT  <= 32'h00000000;
		end
		else
		begin
			if (HOST_REQ_IN.rd)
				HOST_RDATA_OUT <= host_rdata;
			if (SEQ_REQ_IN.rd)
				SEQ_RDATA_OUT <= seq_rdata;
		end
	end

	assign CUSTOM_IRQ_OUT = custom_flag;
	assign PIN_IRQ_OUT    = pin_event;
	assign WAKE_REQ_OUT   = |pin_event;

	sequence s_seq_sets_flag0;
		seq_custom_wr && SEQ_REQ_IN.wdata[0] && !custom_flag[0];
	endsequence

	sequence s_pin0_high_taken;
		WAKE_PIN_0_IN;
	endsequence

	sequence s_pin0_high_armed;
		pin0_wake_enable && pin0_detect_mode == 3'b011;
	endsequence

	sequence s_pin1_high_taken;
		WAKE_PIN_1_IN;
	endsequence

	// both level codes count, so the alias shares the same latency check
	sequence s_pin1_high_armed;
		pin1_wake_enable && (pin1_detect_mode == 3'b011 || pin1_detect_mode == 3'b111);
	endsequence

	a_host_write_ignored: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		!seq_custom_wr |=> custom_flag == $past(custom_flag))
		else $error("custom flags changed without a sequencer write");
	a_custom_raise: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		s_seq_sets_flag0 |=> CUSTOM_IRQ_OUT[0])
		else $error("custom interrupt 0 not raised");
	a_custom_w1c: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		seq_custom_wr && SEQ_REQ_IN.wdata[1] && custom_flag[1] |=> !custom_flag[1])
		else $error("custom flag 1 not cleared by write of one");
	a_custom_reserved: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		SEQ_REQ_IN.rd && SEQ_REQ_IN.addr == OFS_CUSTOM_GEN |=> SEQ_RDATA_OUT[31:4] == 28'h0000001)
		else $error("reserved custom bits read wrong");
	a_disabled_quiet: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		!pin0_wake_enable |=> !PIN_IRQ_OUT[0])
		else $error("pin 0 interrupt while disabled");
	a_rise_detect: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		pin0_wake_enable && pin0_detect_mode == 3'b000 && pin_sync[0] && !pin_prev[0] |=> PIN_IRQ_OUT[0])
		else $error("rising edge on pin 0 missed");
	a_high_alias: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		pin1_wake_enable && pin1_detect_mode == 3'b111 && pin_sync[1] |=> PIN_IRQ_OUT[1])
		else $error("high level alias on pin 1 missed");
	a_level_latency: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		s_pin1_high_taken ##2 s_pin1_high_armed |=> PIN_IRQ_OUT[1])
		else $error("level interrupt on pin 1 late");
	a_wake_pin1: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		PIN_IRQ_OUT[1] |-> WAKE_REQ_OUT)
		else $error("pin 1 event did not request wake-up");

	a_custom_raise1: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		seq_custom_wr && SEQ_REQ_IN.wdata[1] && !custom_flag[1] |=> CUSTOM_IRQ_OUT[1])
		else $error("custom interrupt 1 not raised");
	a_custom_raise2: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		seq_custom_wr && SEQ_REQ_IN.wdata[2] && !custom_flag[2] |=> CUSTOM_IRQ_OUT[2])
		else $error("custom interrupt 2 not raised");
	a_custom_raise3: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		seq_custom_wr && SEQ_REQ_IN.wdata[3] && !custom_flag[3] |=> CUSTOM_IRQ_OUT[3])
		else $error("custom interrupt 3 not raised");
	a_custom_w1c0: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		seq_custom_wr && SEQ_REQ_IN.wdata[0] && custom_flag[0] |=> !custom_flag[0])
		else $error("custom flag 0 not cleared by write of one");
	a_custom_w1c2: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		seq_custom_wr && SEQ_REQ_IN.wdata[2] && custom_flag[2] |=> !custom_flag[2])
		else $error("custom flag 2 not cleared by write of one");
	a_custom_w1c3: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		seq_custom_wr && SEQ_REQ_IN.wdata[3] && custom_flag[3] |=> !custom_flag[3])
		else $error("custom flag 3 not cleared by write of one");
	a_custom_zero_keeps: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		seq_custom_wr && SEQ_REQ_IN.wdata[3:0] == 4'h0 |=> $stable(custom_flag))
		else $error("custom flags changed by a write of zeros");
	a_host_custom_dead: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		HOST_REQ_IN.wr && HOST_REQ_IN.addr == OFS_CUSTOM_GEN && !seq_custom_wr |=> $stable(custom_flag))
		else $error("host write reached the custom flags");
	a_host_custom_read: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		HOST_REQ_IN.rd && HOST_REQ_IN.addr == OFS_CUSTOM_GEN |=> HOST_RDATA_OUT == 32'h00000000)
		else $error("host view of custom register not zero");
	a_custom_flag_read: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		SEQ_REQ_IN.rd && SEQ_REQ_IN.addr == OFS_CUSTOM_GEN |=> SEQ_RDATA_OUT[3:0] == $past(custom_flag))
		else $error("custom flags read back wrong");

	a_cfg0_write: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		HOST_REQ_IN.wr && HOST_REQ_IN.addr == OFS_EXT_CFG_0 && !(SEQ_REQ_IN.wr && SEQ_REQ_IN.addr == OFS_EXT_CFG_0)
		|=> ext_cfg_0 == $past(HOST_REQ_IN.wdata[15:0]))
		else $error("configuration 0 write lost");
	a_cfg0_readback: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		HOST_REQ_IN.rd && HOST_REQ_IN.addr == OFS_EXT_CFG_0 |=> HOST_RDATA_OUT == {16'h0000, $past(ext_cfg_0)})
		else $error("configuration 0 read back wrong");
	a_cfg1_write: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		HOST_REQ_IN.wr && HOST_REQ_IN.addr == OFS_EXT_CFG_1 && !(SEQ_REQ_IN.wr && SEQ_REQ_IN.addr == OFS_EXT_CFG_1)
		|=> ext_cfg_1 == $past(HOST_REQ_IN.wdata[15:0]))
		else $error("configuration 1 write lost");
	a_cfg2_write: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		HOST_REQ_IN.wr && HOST_REQ_IN.addr == OFS_EXT_CFG_2 && !(SEQ_REQ_IN.wr && SEQ_REQ_IN.addr == OFS_EXT_CFG_2)
		|=> ext_cfg_2 == $past(HOST_REQ_IN.wdata[15:0]))
		else $error("configuration 2 write lost");
	a_clear_write: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		HOST_REQ_IN.wr && HOST_REQ_IN.addr == OFS_EXT_CLEAR && !(SEQ_REQ_IN.wr && SEQ_REQ_IN.addr == OFS_EXT_CLEAR)
		|=> ext_clear == $past(HOST_REQ_IN.wdata[15:0]))
		else $error("clear register write lost");
	a_cfg_upper_zero: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		HOST_REQ_IN.rd && (HOST_REQ_IN.addr == OFS_EXT_CFG_1 || HOST_REQ_IN.addr == OFS_EXT_CFG_2)
		|=> HOST_RDATA_OUT[31:16] == 16'h0000)
		else $error("upper half of a configuration read not zero");

	a_fall_detect: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		pin0_wake_enable && pin0_detect_mode == 3'b001 && !pin_sync[0] && pin_prev[0] |=> PIN_IRQ_OUT[0])
		else $error("falling edge on pin 0 missed");
	a_fall_alias: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		pin0_wake_enable && pin0_detect_mode == 3'b101 && !pin_sync[0] && pin_prev[0] |=> PIN_IRQ_OUT[0])
		else $error("falling edge alias on pin 0 missed");
	a_both_detect: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		pin0_wake_enable && pin0_detect_mode == 3'b010 && pin_sync[0] != pin_prev[0] |=> PIN_IRQ_OUT[0])
		else $error("either edge on pin 0 missed");
	a_both_alias: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		pin0_wake_enable && pin0_detect_mode == 3'b110 && pin_sync[0] != pin_prev[0] |=> PIN_IRQ_OUT[0])
		else $error("either edge alias on pin 0 missed");
	a_high_level: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		pin0_wake_enable && pin0_detect_mode == 3'b011 && pin_sync[0] |=> PIN_IRQ_OUT[0])
		else $error("high level on pin 0 missed");
	a_low_level: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		pin0_wake_enable && pin0_detect_mode == 3'b100 && !pin_sync[0] |=> PIN_IRQ_OUT[0])
		else $error("low level on pin 0 missed");
	a_rise_quiet: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		pin0_detect_mode == 3'b000 && !pin_sync[0] |=> !PIN_IRQ_OUT[0])
		else $error("rising edge mode fired on a low pin 0");
	a_low_quiet: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		pin0_detect_mode == 3'b100 && pin_sync[0] |=> !PIN_IRQ_OUT[0])
		else $error("low level mode fired on a high pin 0");
	a_rise_one_cycle: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		PIN_IRQ_OUT[0] && pin0_detect_mode == 3'b000 && $stable(ext_cfg_0) |=> !PIN_IRQ_OUT[0])
		else $error("rising edge event on pin 0 longer than one cycle");
	a_pin1_disabled: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		!pin1_wake_enable |=> !PIN_IRQ_OUT[1])
		else $error("pin 1 interrupt while disabled");
	a_pin1_low: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		pin1_wake_enable && pin1_detect_mode == 3'b100 && !pin_sync[1] |=> PIN_IRQ_OUT[1])
		else $error("low level on pin 1 missed");
	a_pin1_fall_alias: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		pin1_wake_enable && pin1_detect_mode == 3'b101 && !pin_sync[1] && pin_prev[1] |=> PIN_IRQ_OUT[1])
		else $error("falling edge alias on pin 1 missed");
	a_pin0_level_latency: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		s_pin0_high_taken ##2 s_pin0_high_armed |=> PIN_IRQ_OUT[0])
		else $error("level interrupt on pin 0 late");
	a_level_release: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		pin1_detect_mode == 3'b011 && !pin_sync[1] |=> !PIN_IRQ_OUT[1])
		else $error("level interrupt on pin 1 outlived its level");
	a_wake_pin0: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		PIN_IRQ_OUT[0] |-> WAKE_REQ_OUT)
		else $error("pin 0 event did not request wake-up");
	a_wake_needs_event: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		PIN_IRQ_OUT == 2'b00 |-> !WAKE_REQ_OUT)
		else $error("wake-up requested without a pin event");
endmodule

// [cig_pin_src.sv]
// partner model: the two wake pin signal sources
`timescale 1ns/100ps
module cig_pin_src
(
	input  wire logic       clk_in,
	input  wire logic [1:0] level_in,
	output logic [1:0]      pin_out
);
	// pins move only on a clock edge, so detection latency stays fixed
	always_ff @(posedge clk_in)
	begin
		pin_out <= level_in;
	end
endmodule

// [cig_int_config_test.sv]
// testbench: register access, custom flags and pin detection modes
`timescale 1ns/100ps
module cig_int_config_test
	import cig_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	cig_req_s    hreq = '0;
	cig_req_s    sreq = '0;
	logic [31:0] hrdata;
	logic [31:0] srdata;
	logic [1:0]  lvl = 2'b00;
	logic [1:0]  pins;
	logic [3:0]  cirq;
	logic [1:0]  pirq;
	logic        wake;
	int          errors = 0;
	int          check_count = 0;
	int          nirq;
	int          nwake;
	int          exp_cnt [8] = '{1, 1, 2, 8, 16, 1, 2, 8};

	initial
	begin
		forever #12.5 clk = ~clk;
	end

	cig_int_config i_cig_int_config (.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .HOST_REQ_IN(hreq), .HOST_RDATA_OUT(hrdata),
		.SEQ_REQ_IN(sreq), .SEQ_RDATA_OUT(srdata), .WAKE_PIN_0_IN(pins[0]), .WAKE_PIN_1_IN(pins[1]),
		.CUSTOM_IRQ_OUT(cirq), .PIN_IRQ_OUT(pirq), .WAKE_REQ_OUT(wake));
	cig_pin_src i_cig_pin_src (.clk_in(clk), .level_in(lvl), .pin_out(pins));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one-cycle pulse; a free cycle before it keeps release and next request apart
	task automatic access(input bit seq, input bit wr, input logic [15:0] a, input logic [31:0] d);
		cig_req_s r;
		r = '{wr: wr, rd: ~wr, addr: a, wdata: d};
		@(posedge clk);
		#1;
		if (seq)
			sreq = r;
		else
			hreq = r;
		@(posedge clk);
		#1;
		sreq = '0;
		hreq = '0;
	endtask

	task automatic rd(input bit seq, input logic [15:0] a, input logic [31:0] exp);
		access(seq, 1'b0, a, 32'h0);
		check(seq ? srdata : hrdata, exp);
	endtask

	// pin high for 8 cycles inside a 24-cycle counting window
	task automatic wave(input int p);
		nirq = 0;
		nwake = 0;
		for (int i = 0; i < 30; i++)
		begin
			@(posedge clk);
			#1;
			if (i == 6)
				lvl[p] = 1'b1;
			if (i == 14)
				lvl[p] = 1'b0;
			@(negedge clk);
			nirq += (i >= 6 && pirq[p] === 1'b1);
			nwake += (i >= 6 && wake === 1'b1);
		end
	endtask

	task automatic complete_run;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (5) @(posedge clk);
		#1;
		rst_n = 1'b1;
		rd(0, OFS_EXT_CFG_0, 32'h0);
		rd(0, OFS_EXT_CFG_1, 32'h0);
		rd(0, OFS_EXT_CFG_2, 32'h0);
		rd(0, OFS_EXT_CLEAR, 32'hc000);
		rd(1, OFS_CUSTOM_GEN, 32'h10);
		access(0, 1, OFS_CUSTOM_GEN, 32'hf);
		access(0, 0, OFS_CUSTOM_GEN, 32'h0);
		rd(1, OFS_CUSTOM_GEN, 32'h10);
		check(cirq, 4'h0);
		for (int k = 0; k < 4; k++)
		begin
			access(1, 1, OFS_CUSTOM_GEN, 32'h1 << k);
			repeat (2) @(negedge clk);
			check(cirq, 4'h1 << k);
			access(1, 1, OFS_CUSTOM_GEN, 32'h1 << k);
			repeat (2) @(negedge clk);
			check(cirq, 4'h0);
		end
		access(1, 1, OFS_CUSTOM_GEN, 32'hffffffff);
		rd(1, OFS_CUSTOM_GEN, 32'h1f);
		access(1, 1, OFS_CUSTOM_GEN, 32'hfffffff0);
		rd(1, OFS_CUSTOM_GEN, 32'h1f);
		access(1, 1, OFS_CUSTOM_GEN, 32'hf);
		rd(1, OFS_CUSTOM_GEN, 32'h10);
		access(0, 1, OFS_EXT_CFG_1, 32'ha5a5);
		rd(0, OFS_EXT_CFG_1, 32'ha5a5);
		access(0, 1, OFS_EXT_CFG_2, 32'h5a5a);
		rd(0, OFS_EXT_CFG_2, 32'h5a5a);
		access(0, 1, OFS_EXT_CLEAR, 32'h1234);
		rd(0, OFS_EXT_CLEAR, 32'h1234);
		access(1, 1, OFS_CUSTOM_GEN, 32'h4);
		check(cirq, 4'h4);
		// a reset in mid-run must put back every written register
		@(posedge clk);
		#1;
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		rd(0, OFS_EXT_CFG_1, 32'h0);
		rd(0, OFS_EXT_CFG_2, 32'h0);
		rd(0, OFS_EXT_CLEAR, 32'hc000);
		rd(1, OFS_CUSTOM_GEN, 32'h10);
		check(cirq, 4'h0);
		access(0, 1, 16'h0a2c, 32'hffff);
		rd(0, 16'h0a2c, 32'h0);
		for (int p = 0; p < 2; p++)
			for (int m = 0; m < 8; m++)
			begin
				access(0, 1, OFS_EXT_CFG_0, 32'(8 + m) << (4 * p));
				wave(p);
				check(nirq, exp_cnt[m]);
				check(nwake, exp_cnt[m]);
			end
		access(0, 1, OFS_EXT_CFG_0, 32'h0);
		wave(0);
		check(nirq, 0);
		check(nwake, 0);
		complete_run;
	end

	initial
	begin
		#100000;
		errors++;
		complete_run;
	end
endmodule
